// ==== src/fwp_pkg.sv ====
// Purpose: shared constants and types for feedback word processing
// Assumes: one clock, synchronous active-high reset
// Notes:   both ends and the interface use these names
package fwp_pkg;

  localparam int unsigned WORD_W     = 16;
  localparam int unsigned SHIFT_W    = 4;
  localparam int unsigned LEN_W      = 5;
  localparam int unsigned OFS_W      = 12;
  localparam int unsigned RES_W      = 17;
  localparam int unsigned SEL_W      = 3;

  localparam logic [SHIFT_W-1:0] SHIFT_MAX  = 4'hf;
  localparam logic [LEN_W-1:0]   LEN_MIN    = 5'h01;
  localparam logic [LEN_W-1:0]   LEN_MAX    = 5'h10;
  localparam logic [LEN_W-1:0]   LEN_TABLE  = 5'h0c;
  localparam logic [OFS_W-1:0]   OFS_MAX    = 12'hfff;

  // settings after reset: pass-through (shift 0, full length, offset 0)
  localparam logic [SHIFT_W-1:0] SHIFT_RST  = 4'h0;
  localparam logic [LEN_W-1:0]   LEN_RST    = 5'h10;
  localparam logic [OFS_W-1:0]   OFS_RST    = 12'h000;

  // cycles the configure instruction blocks the sequencer
  localparam int unsigned CFG_BUSY_CYC    = 2;
  // countdown load: busy covers the ack cycle and the one after it
  localparam logic [1:0]  CFG_BUSY_CNT    = 2'(CFG_BUSY_CYC);
  // least waveform length during configure for gap-free output
  localparam int unsigned GAPFREE_SAMPLES = 48;

  // register offsets of the controller's own register file
  localparam logic [3:0] ADDR_CFG   = 4'h0;
  localparam logic [3:0] ADDR_CMD   = 4'h1;
  localparam logic [3:0] ADDR_STAT  = 4'h2;
  localparam logic [3:0] ADDR_VAL   = 4'h3;
  localparam logic [3:0] ADDR_WORD  = 4'h4;

  // command register field positions
  localparam int unsigned CMD_OP_LSB  = 0;
  localparam int unsigned CMD_SEL_LSB = 2;

  typedef enum logic [SEL_W-1:0] {
    FWP_SRC_RAW    = 3'b000,
    FWP_SRC_PROC_A = 3'b001,
    FWP_SRC_PROC_B = 3'b010,
    FWP_SRC_LEG_R  = 3'b011,
    FWP_SRC_LEG_D  = 3'b100
  } fwp_src_e;

  typedef enum logic [1:0] {
    FWP_OP_NONE = 2'b00,
    FWP_OP_CFG  = 2'b01,
    FWP_OP_READ = 2'b10,
    FWP_OP_PLAY = 2'b11
  } fwp_op_e;

endpackage : fwp_pkg

// ==== src/fwp_if.sv ====
// Purpose: carrier between sequencer controller and feedback processor
// Assumes: both ends on core_clk
// Notes:   req/ack handshake, one request outstanding
`timescale 1ns/1ps
interface fwp_if;
  logic                               fb_valid;
  logic [fwp_pkg::WORD_W-1:0]         fb_word;
  logic                               req;
  fwp_pkg::fwp_op_e                   op;
  fwp_pkg::fwp_src_e                  feedback_path_select;
  logic [fwp_pkg::SHIFT_W-1:0]        shift;
  logic [fwp_pkg::LEN_W-1:0]          length;
  logic [fwp_pkg::OFS_W-1:0]          offset;
  logic                               ack;
  logic [fwp_pkg::RES_W-1:0]          result;
  logic                               busy;

  modport dev (
    input  fb_valid, fb_word, req, op, feedback_path_select, shift, length, offset,
    output ack, result, busy
  );
  modport seq (
    output req, op, feedback_path_select, shift, length, offset,
    input  ack, result, busy
  );
endinterface : fwp_if

// ==== src/fwp_proc.sv ====
// Purpose: feedback word processing chains on the device end
// Assumes: link word arrives in-domain with a valid strobe
// Notes:   one raw chain plus two processed chains
`timescale 1ns/1ps

module fwp_proc (
  input  wire logic core_clk,
  input  wire logic rst,
  fwp_if.dev        bus
);

  logic [fwp_pkg::WORD_W-1:0]  word_reg, word_next;
  logic [fwp_pkg::SHIFT_W-1:0] shift_reg [2], shift_next [2];
  logic [fwp_pkg::LEN_W-1:0]   len_reg [2], len_next [2];
  logic [fwp_pkg::OFS_W-1:0]   ofs_reg [2], ofs_next [2];
  logic [fwp_pkg::RES_W-1:0]   proc_val [2];
  logic [fwp_pkg::RES_W-1:0]   result_reg, result_next;
  logic                        ack_reg, ack_next;
  logic [1:0]                  busy_reg, busy_next;
  logic                        path_idx;
  logic                        is_proc;

  // one processing chain per processed path
  for (genvar p = 0; p < 2; p++) begin : g_chain
    logic [fwp_pkg::WORD_W-1:0] shifted;
    logic [fwp_pkg::WORD_W:0]   mask_w;
    assign shifted = word_reg >> shift_reg[p];
    assign mask_w  = (17'h00001 << len_reg[p]) - 17'h00001;
    assign proc_val[p] = {1'b0, shifted & mask_w[fwp_pkg::WORD_W-1:0]}
                         + {5'h00, ofs_reg[p]};
  end

  // source decode, legacy aliases fold onto paths
  always_comb begin
    is_proc  = 1'b1;
    path_idx = 1'b0;
    case (bus.feedback_path_select)
      fwp_pkg::FWP_SRC_PROC_A, fwp_pkg::FWP_SRC_LEG_R: path_idx = 1'b0;
      fwp_pkg::FWP_SRC_PROC_B, fwp_pkg::FWP_SRC_LEG_D: path_idx = 1'b1;
      default: is_proc = 1'b0;
    endcase
  end

  // next-state: capture word, configure, answer
  always_comb begin
    word_next   = word_reg;
    shift_next  = shift_reg;
    len_next    = len_reg;
    ofs_next    = ofs_reg;
    result_next = result_reg;
    ack_next    = 1'b0;
    busy_next   = (busy_reg != 2'h0) ? busy_reg - 2'h1 : 2'h0;
    if (bus.fb_valid) begin
      word_next = bus.fb_word;
    end
    if (bus.req && !ack_reg && busy_reg == 2'h0) begin
      ack_next = 1'b1;
      if (bus.op == fwp_pkg::FWP_OP_CFG) begin
        if (is_proc) begin
          // out-of-range values clamp into the legal span
          shift_next[path_idx] = bus.shift;
          len_next[path_idx]   = (bus.length < fwp_pkg::LEN_MIN) ? fwp_pkg::LEN_MIN :
                                 (bus.length > fwp_pkg::LEN_MAX) ? fwp_pkg::LEN_MAX :
                                 bus.length;
          ofs_next[path_idx]   = bus.offset;
        end
        busy_next = fwp_pkg::CFG_BUSY_CNT;
      end else if (bus.op != fwp_pkg::FWP_OP_NONE) begin
        // uses settings held before this cycle's update
        result_next = is_proc ? proc_val[path_idx]
                              : {1'b0, word_reg};
      end
    end
  end

  // register stage, reset gives pass-through settings
  always_ff @(posedge core_clk) begin
    if (rst) begin
      word_reg   <= '0;
      for (int i = 0; i < 2; i++) begin
        shift_reg[i] <= fwp_pkg::SHIFT_RST;
        len_reg[i]   <= fwp_pkg::LEN_RST;
        ofs_reg[i]   <= fwp_pkg::OFS_RST;
      end
      result_reg <= '0;
      ack_reg    <= 1'b0;
      busy_reg   <= 2'h0;
    end else begin
      word_reg   <= word_next;
      shift_reg  <= shift_next;
      len_reg    <= len_next;
      ofs_reg    <= ofs_next;
      result_reg <= result_next;
      ack_reg    <= ack_next;
      busy_reg   <= busy_next;
    end
  end

  assign bus.ack    = ack_reg;
  assign bus.result = result_reg;
  assign bus.busy   = ack_reg | (busy_reg != 2'h0);

endmodule : fwp_proc

// ==== src/fwp_seq.sv ====
// Purpose: sequencer-side controller issuing feedback operations
// Assumes: software drives plain register port on core_clk
// Notes:   one operation in flight; status shows busy, value register holds last result
`timescale 1ns/1ps
module fwp_seq (
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  fwp_if.seq                              bus,
  input  wire logic [3:0]                 addr,
  input  wire logic [31:0]                wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic      [31:0]                rdata,
  output logic                            branch_take,
  output logic                            play_valid,
  output logic      [11:0]                play_index
);

  logic [31:0]                  cfg_reg, cfg_next;
  logic                         req_reg, req_next;
  fwp_pkg::fwp_op_e             op_reg, op_next;
  fwp_pkg::fwp_src_e            sel_reg, sel_next;
  logic [fwp_pkg::RES_W-1:0]    val_reg, val_next;
  logic                         br_reg, br_next;
  logic                         pv_reg, pv_next;
  logic [11:0]                  pi_reg, pi_next;
  logic [31:0]                  rdata_reg, rdata_next;

  // command write starts op; ack ends it
  always_comb begin
    cfg_next = cfg_reg;
    req_next = req_reg;
    op_next  = op_reg;
    sel_next = sel_reg;
    val_next = val_reg;
    br_next  = 1'b0;
    pv_next  = 1'b0;
    pi_next  = pi_reg;
    if (wr && addr == fwp_pkg::ADDR_CFG) begin
      cfg_next = wdata;
    end else if (wr && addr == fwp_pkg::ADDR_CMD && !req_reg) begin
      req_next = 1'b1; // source named with each op
      op_next  = fwp_pkg::fwp_op_e'(wdata[fwp_pkg::CMD_OP_LSB +: 2]);
      sel_next = fwp_pkg::fwp_src_e'(wdata[fwp_pkg::CMD_SEL_LSB +: fwp_pkg::SEL_W]);
    end
    if (req_reg && bus.ack) begin
      req_next = 1'b0;
      if (op_reg != fwp_pkg::FWP_OP_CFG) begin
        val_next = bus.result;
        br_next  = (bus.result != '0) && (op_reg == fwp_pkg::FWP_OP_READ);
        pv_next  = (op_reg == fwp_pkg::FWP_OP_PLAY);
        pi_next  = bus.result[11:0];
      end
    end
  end

  // read mux, data stand one cycle later
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (rd && addr == fwp_pkg::ADDR_CFG) begin
      rdata_next = cfg_reg;
    end else if (rd && addr == fwp_pkg::ADDR_STAT) begin
      rdata_next = {31'h0000_0000, req_reg | bus.busy};
    end else if (rd && addr == fwp_pkg::ADDR_VAL) begin
      rdata_next = {15'h0000, val_reg};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_reg   <= 32'h0000_0000;
      req_reg   <= 1'b0;
      op_reg    <= fwp_pkg::FWP_OP_NONE;
      sel_reg   <= fwp_pkg::FWP_SRC_RAW;
      val_reg   <= '0;
      br_reg    <= 1'b0;
      pv_reg    <= 1'b0;
      pi_reg    <= 12'h000;
      rdata_reg <= 32'h0000_0000;
    end else begin
      cfg_reg   <= cfg_next;
      req_reg   <= req_next;
      op_reg    <= op_next;
      sel_reg   <= sel_next;
      val_reg   <= val_next;
      br_reg    <= br_next;
      pv_reg    <= pv_next;
      pi_reg    <= pi_next;
      rdata_reg <= rdata_next;
    end
  end

  // configuration fields: shift [3:0], length [8:4], offset [27:16]
  assign bus.req                  = req_reg;
  assign bus.op                   = op_reg;
  assign bus.feedback_path_select = sel_reg;
  assign bus.shift                = cfg_reg[3:0];
  assign bus.length               = cfg_reg[8:4];
  assign bus.offset               = cfg_reg[27:16];
  assign rdata                    = rdata_reg;
  assign branch_take              = br_reg;
  assign play_valid               = pv_reg;
  assign play_index               = pi_reg;

endmodule : fwp_seq

// ==== bench/fwp_asserts.sv ====
// Purpose: assertions on the carrier between the two ends
// Assumes: one clock, synchronous active-high reset
// Notes:   keeps its own copy of path settings to predict results
`timescale 1ns/1ps
module fwp_asserts (
  input wire logic                        core_clk,
  input wire logic                        rst,
  input wire logic                        fb_valid,
  input wire logic [fwp_pkg::WORD_W-1:0]  fb_word,
  input wire logic                        req,
  input wire fwp_pkg::fwp_op_e            op,
  input wire fwp_pkg::fwp_src_e           feedback_path_select,
  input wire logic [fwp_pkg::SHIFT_W-1:0] shift,
  input wire logic [fwp_pkg::LEN_W-1:0]   length,
  input wire logic [fwp_pkg::OFS_W-1:0]   offset,
  input wire logic                        ack,
  input wire logic [fwp_pkg::RES_W-1:0]   result,
  input wire logic                        busy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [15:0] word_reg;
  logic [3:0]  sh_reg [2];
  logic [4:0]  ln_reg [2];
  logic [11:0] of_reg [2];
  logic        rdp;
  logic        pb;
  // answer to a read or play, and which processed path is named
  assign rdp = ack && (op == fwp_pkg::FWP_OP_READ || op == fwp_pkg::FWP_OP_PLAY);
  assign pb  = (feedback_path_select == fwp_pkg::FWP_SRC_PROC_B ||
                feedback_path_select == fwp_pkg::FWP_SRC_LEG_D);
  function automatic logic [16:0] calc(input logic [15:0] w, input logic [3:0] s,
                                       input logic [4:0] l, input logic [11:0] o);
    calc = 17'((w >> s) & 16'((17'h1 << l) - 17'h1)) + 17'(o);
  endfunction : calc
  // last link word and settings taken at each configure answer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        sh_reg[i] <= 4'h0;
        ln_reg[i] <= 5'h10;
        of_reg[i] <= 12'h000;
      end
    end else begin
      if (fb_valid) word_reg <= fb_word;
      if (ack && op == fwp_pkg::FWP_OP_CFG) begin
        sh_reg[pb] <= shift;
        ln_reg[pb] <= length;
        of_reg[pb] <= offset;
      end
    end
  end
  sequence s_cfg_block;
    busy ##1 busy ##1 !busy;
  endsequence
  a_ack_in_time: assert property (req && !busy && !ack |=> ack)
    else $error("ack late");
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_cfg_blocks: assert property (ack && op == fwp_pkg::FWP_OP_CFG |-> s_cfg_block)
    else $error("configure busy span wrong");
  a_raw_exact: assert property (rdp && feedback_path_select == fwp_pkg::FWP_SRC_RAW
    |-> result == {1'b0, word_reg}) else $error("raw result altered");
  a_path_a_calc: assert property (rdp && !pb && feedback_path_select != 0
    |-> result == calc(word_reg, sh_reg[0], ln_reg[0], of_reg[0])) else $error("path a wrong");
  a_path_b_calc: assert property (rdp && pb
    |-> result == calc(word_reg, sh_reg[1], ln_reg[1], of_reg[1])) else $error("path b wrong");
  a_result_hold: assert property ($changed(result) |-> rdp)
    else $error("result moved without read");
  a_req_held: assert property (req && !ack |=> req && $stable(op) && $stable(length))
    else $error("request dropped early");
  a_len_range: assert property (req && op == fwp_pkg::FWP_OP_CFG |-> length inside {[1:16]})
    else $error("length out of range");
endmodule : fwp_asserts

// ==== bench/feedback_word_processing_tb_top.sv ====
// Purpose: self-checking bench for both ends joined by the carrier
// Assumes: core_clk 200 MHz, rst held 5 cycles
// Notes:   random settings from seed 88, bench model predicts results
`timescale 1ns/1ps
module feedback_word_processing_tb_top;
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic [3:0]  addr     = 4'h0;
  logic [31:0] wdata    = 32'h0;
  logic        wr       = 1'b0;
  logic        rd       = 1'b0;
  logic [31:0] rdata;
  logic        branch_take;
  logic        play_valid;
  logic [11:0] play_index;
  logic [31:0] got;
  logic [3:0]  sh [3];
  logic [4:0]  ln [3];
  logic [11:0] of [3];
  integer      seed       = 88;
  int          n_mismatch = 0;
  int          compares   = 0;
  int          n_br       = 0;
  int          n_pv       = 0;
  fwp_if fi ();
  // pulse counters for the one-cycle status outputs
  always @(posedge core_clk) begin
    if (branch_take) n_br <= n_br + 1;
    if (play_valid) n_pv <= n_pv + 1;
  end
  always #2.5 core_clk = ~core_clk;
  fwp_proc fwp_proc_i (.core_clk(core_clk), .rst(rst), .bus(fi.dev));
  fwp_seq fwp_seq_i (.core_clk(core_clk), .rst(rst), .bus(fi.seq), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .branch_take(branch_take),
    .play_valid(play_valid), .play_index(play_index));
  fwp_asserts fwp_asserts_i (.core_clk(core_clk), .rst(rst), .fb_valid(fi.fb_valid),
    .fb_word(fi.fb_word), .req(fi.req), .op(fi.op), .shift(fi.shift),
    .feedback_path_select(fi.feedback_path_select), .length(fi.length),
    .offset(fi.offset), .ack(fi.ack), .result(fi.result), .busy(fi.busy));
  // selector to model slot: raw 0, path a 1, path b 2
  function automatic int slot(input logic [2:0] s);
    slot = (s == 3'h1 || s == 3'h3) ? 1 : (s == 3'h0) ? 0 : 2;
  endfunction : slot
  function automatic logic [31:0] exp_val(input logic [2:0] s, input logic [15:0] w);
    int p;
    p = slot(s);
    exp_val = 32'((w >> sh[p]) & 16'((17'h1 << ln[p]) - 17'h1)) + 32'(of[p]);
  endfunction : exp_val
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [3:0] a);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask : rreg
  // command, then the handshake span the hand-over fixes
  task automatic run(input fwp_pkg::fwp_op_e o, input logic [2:0] s);
    wreg(fwp_pkg::ADDR_CMD, {27'h0, s, o});
    repeat (5) @(posedge core_clk);
  endtask : run
  task automatic send(input logic [15:0] w);
    @(posedge core_clk);
    fi.fb_valid <= 1'b1;
    fi.fb_word  <= w;
    @(posedge core_clk);
    fi.fb_valid <= 1'b0;
  endtask : send
  task automatic cfg(input logic [2:0] p, input logic [3:0] s, input logic [4:0] l,
                     input logic [11:0] o);
    wreg(fwp_pkg::ADDR_CFG, {4'h0, o, 7'h0, l, s});
    run(fwp_pkg::FWP_OP_CFG, p);
    sh[slot(p)] = s;
    ln[slot(p)] = l;
    of[slot(p)] = o;
  endtask : cfg
  // every selector read back and played for one word
  task automatic check_all(input logic [15:0] w);
    int nb;
    int np;
    for (int s = 0; s < 5; s++) begin
      nb = n_br;
      np = n_pv;
      run(fwp_pkg::FWP_OP_READ, 3'(s));
      chk(32'(n_br - nb), {31'h0, exp_val(3'(s), w) != 32'h0});
      chk(32'(n_pv - np), 32'h0);
      rreg(fwp_pkg::ADDR_VAL);
      chk(got, exp_val(3'(s), w));
      nb = n_br;
      np = n_pv;
      run(fwp_pkg::FWP_OP_PLAY, 3'(s));
      chk(32'(n_pv - np), 32'h1);
      chk(32'(n_br - nb), 32'h0);
      chk({20'h0, play_index}, {20'h0, exp_val(3'(s), w) & 32'hfff});
    end
  endtask : check_all
  initial begin : watchdog
    #200000;
    n_mismatch++;
    test_done();
  end
  initial begin : main
    logic [15:0] w;
    fi.fb_valid = 1'b0;
    fi.fb_word  = 16'h0;
    for (int k = 0; k < 3; k++) begin
      sh[k] = 4'h0;
      ln[k] = 5'h10;
      of[k] = 12'h000;
    end
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    send(16'ha5c3);
    check_all(16'ha5c3);
    cfg(3'h1, 4'h0, 5'h10, 12'hfff);
    cfg(3'h2, 4'hf, 5'h01, 12'h000);
    send(16'hffff);
    check_all(16'hffff);
    for (int n = 0; n < 24; n++) begin
      w = 16'($random(seed));
      cfg(3'({$random(seed)} % 4 + 1), 4'($random(seed)), 5'({$random(seed)} % 16 + 1),
          12'($random(seed)));
      send(w);
      check_all(w);
    end
    run(fwp_pkg::FWP_OP_NONE, 3'h2);
    rreg(fwp_pkg::ADDR_VAL);
    chk(got, exp_val(3'h4, w));
    rreg(4'h4);
    chk(got, 32'h0);
    rreg(fwp_pkg::ADDR_STAT);
    chk(got & 32'h1, 32'h0);
    test_done();
  end
  task automatic test_done;
    $display("mismatches=%0d compares=%0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
endmodule : feedback_word_processing_tb_top
